// ==== design/tcc_pkg.sv ====
// Purpose: shared constants and types of the timer capture/compare block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes: channel registers sit at a base plus channel times stride
package tcc_pkg;
	// ==========================================================
	// sizes
	localparam int TCC_CNT_W = 16;
	localparam int TCC_NCH = 4;
	localparam int TCC_ADDR_W = 8;
	localparam int TCC_DATA_W = 32;

	// ==========================================================
	// register offsets
	localparam logic [7:0] TCC_OFS_CTRL = 8'h00;
	localparam logic [7:0] TCC_OFS_COUNT = 8'h04;
	localparam logic [7:0] TCC_OFS_DIV = 8'h08;
	localparam logic [7:0] TCC_OFS_WRAP = 8'h0C;
	localparam logic [7:0] TCC_OFS_STATUS = 8'h10;
	localparam logic [7:0] TCC_OFS_MASK = 8'h14;
	localparam logic [7:0] TCC_OFS_CFG_BASE = 8'h20;
	localparam logic [7:0] TCC_OFS_VAL_BASE = 8'h40;
	localparam logic [7:0] TCC_CHAN_STRIDE = 8'h04;

	// ==========================================================
	// field positions
	localparam int TCC_CTRL_EN_BIT = 0;
	localparam int TCC_CTRL_DIR_LSB = 1;
	localparam int TCC_CTRL_ENC_LSB = 3;
	localparam int TCC_CFG_MODE_LSB = 0;
	localparam int TCC_CFG_POL_BIT = 4;
	localparam int TCC_CFG_EDGE_LSB = 5;

	// ==========================================================
	// field encodings
	typedef enum logic [1:0] {TCC_DIR_UP, TCC_DIR_DOWN, TCC_DIR_CENTER, TCC_DIR_RSVD} tcc_dir_t;
	typedef enum logic [1:0] {TCC_ENC_OFF, TCC_QUAD_COUNT_FIRST_ONLY, TCC_QUAD_COUNT_SECOND_ONLY,
		TCC_QUAD_COUNT_BOTH} tcc_enc_t;
	typedef enum logic [1:0] {TCC_EDGE_RISE, TCC_EDGE_FALL, TCC_EDGE_BOTH, TCC_EDGE_RSVD} tcc_edge_t;
	typedef enum logic [3:0] {
		TCC_PWM_MODE,
		TCC_PWM_ACTIVE_LOW_MODE,
		TCC_MATCH_TIMING_MODE,
		TCC_MATCH_ACTIVE_MODE,
		TCC_MATCH_INACTIVE_MODE,
		TCC_MATCH_TOGGLE_MODE,
		TCC_FORCED_ACTIVE_MODE,
		TCC_FORCED_INACTIVE_MODE,
		TCC_EDGE_LATCH_MODE
	} tcc_mode_t;
endpackage : tcc_pkg

// ==== design/tcc_chan.sv ====
// Purpose: one channel: pwm, output compare and edge latch decisions
// Assumes: step_i marks each cycle in which the shared counter moves
// Notes: the value register lives in the parent; capture is a request
`timescale 1ns/1ps
module tcc_chan
	import tcc_pkg::*;
#(
	parameter int CNT_W = TCC_CNT_W
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// configuration
	input wire tcc_mode_t mode_i,
	input wire logic pol_low_i,
	input wire tcc_edge_t edge_i,
	input wire logic center_i,
	// shared counter and channel value
	input wire logic [CNT_W-1:0] count_i,
	input wire logic [CNT_W-1:0] wrap_i,
	input wire logic step_i,
	input wire logic [CNT_W:0] value_i,
	// primary pin sample
	input wire logic in_now_i,
	input wire logic in_prev_i,
	// results
	output logic pin_o,
	output logic pin_n_o,
	output logic oe_o,
	output logic capture_o,
	output logic event_o
);
	// ==========================================================
	// decisions
	logic match;
	logic cap_edge;
	logic pwm_act;
	logic oc_state;
	logic next_oc_state;
	logic next_pin;

	assign match = step_i && ({1'b0, count_i} == value_i);
	// center mode peaks once at wrap, so value equal to wrap must stay active there
	assign pwm_act = ({1'b0, count_i} < value_i)
		|| (center_i && value_i >= {1'b0, wrap_i});

	always_comb begin
		case (edge_i)
			TCC_EDGE_RISE: cap_edge = in_now_i && !in_prev_i;
			TCC_EDGE_FALL: cap_edge = !in_now_i && in_prev_i;
			TCC_EDGE_BOTH: cap_edge = in_now_i != in_prev_i;
			default: cap_edge = 1'b0;
		endcase
	end

	// complement has no input path: latching looks only at the primary pin
	assign capture_o = (mode_i == TCC_EDGE_LATCH_MODE) && cap_edge;
	assign event_o = capture_o || (match && mode_i != TCC_EDGE_LATCH_MODE);

	always_comb begin
		case (mode_i)
			TCC_MATCH_ACTIVE_MODE: next_oc_state = match ? 1'b1 : oc_state;
			TCC_MATCH_INACTIVE_MODE: next_oc_state = match ? 1'b0 : oc_state;
			TCC_MATCH_TOGGLE_MODE: next_oc_state = match ? !oc_state : oc_state;
			TCC_FORCED_ACTIVE_MODE: next_oc_state = 1'b1;
			TCC_FORCED_INACTIVE_MODE: next_oc_state = 1'b0;
			default: next_oc_state = oc_state;
		endcase
	end

	always_comb begin
		case (mode_i)
			TCC_PWM_MODE: next_pin = pwm_act;
			TCC_PWM_ACTIVE_LOW_MODE: next_pin = !pwm_act;
			default: next_pin = next_oc_state ^ pol_low_i;
		endcase
	end

	// ==========================================================
	// registered pin state
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			oc_state <= 1'b0;
			pin_o <= 1'b0;
			pin_n_o <= 1'b0;
			oe_o <= 1'b0;
		end else begin
			oc_state <= next_oc_state;
			pin_o <= next_pin;
			pin_n_o <= !next_pin;
			// timing mode and latch mode leave the pin undriven
			oe_o <= mode_i != TCC_MATCH_TIMING_MODE && mode_i != TCC_EDGE_LATCH_MODE;
		end
	end
endmodule : tcc_chan

// ==== design/tcc_timer.sv ====
// Purpose: shared counter, register port and channel array of a general timer
// Assumes: pin inputs are already synchronous to CLOCK_I
// Notes: value width is one bit above the counter so wrap plus one fits
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module tcc_timer
	import tcc_pkg::*;
#(
	parameter int CNT_W = TCC_CNT_W,
	parameter int NCH = TCC_NCH
) (
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic SRST_I,
	// register port
	input wire logic [TCC_ADDR_W-1:0] ADDR_I,
	input wire logic [TCC_DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	output logic [TCC_DATA_W-1:0] RDATA_O,
	// channel pins
	input wire logic [NCH-1:0] CHAN_I,
	output logic [NCH-1:0] CHAN_O,
	output logic [NCH-1:0] CHAN_N_O,
	output logic [NCH-1:0] CHAN_OE_O,
	// interrupt
	output logic IRQ_O
);
	// ==========================================================
	// decode helpers
	function automatic logic chan_hit(input logic [TCC_ADDR_W-1:0] addr,
		input logic [7:0] base, input int idx);
		logic [7:0] target;
		target = 8'(base + 8'(idx) * TCC_CHAN_STRIDE);
		chan_hit = addr == target;
	endfunction : chan_hit

	// ==========================================================
	// state
	logic enable;
	tcc_dir_t dir;
	tcc_enc_t enc;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [CNT_W-1:0] tick_divider_value;
	logic [CNT_W-1:0] div_count;
	logic [CNT_W-1:0] wrap_limit_value;
	logic down_phase;
	logic next_down_phase;
	logic [NCH:0] status;
	logic [NCH:0] mask;
	logic [NCH-1:0] in_prev;
	logic [CNT_W:0] value [NCH];
	tcc_mode_t mode [NCH];
	logic [NCH-1:0] pol_low;
	tcc_edge_t edge_sel [NCH];
	logic [NCH-1:0] cap_req;
	logic [NCH-1:0] chan_event;
	logic [NCH-1:0] pin;
	logic [NCH-1:0] pin_n;
	logic [NCH-1:0] pin_oe;

	logic tick;
	logic step;
	logic wrap_event;
	logic chan_first_input;
	logic chan_second_input;
	logic first_chg;
	logic second_chg;
	logic enc_step;
	logic enc_up;
	logic wr_ctrl;
	logic wr_count;
	logic wr_status;
	logic [TCC_DATA_W-1:0] read_word;

	assign wr_ctrl = WR_I && ADDR_I == TCC_OFS_CTRL;
	assign wr_count = WR_I && ADDR_I == TCC_OFS_COUNT;
	assign wr_status = WR_I && ADDR_I == TCC_OFS_STATUS;

	// ==========================================================
	// control register
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			enable <= 1'b0;
			dir <= TCC_DIR_UP;
			enc <= TCC_ENC_OFF;
		end else if (wr_ctrl) begin
			enable <= WDATA_I[TCC_CTRL_EN_BIT];
			dir <= tcc_dir_t'(WDATA_I[TCC_CTRL_DIR_LSB +: 2]);
			enc <= tcc_enc_t'(WDATA_I[TCC_CTRL_ENC_LSB +: 2]);
		end
	end

	// ==========================================================
	// divider and wrap limit
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			tick_divider_value <= '0;
			wrap_limit_value <= '1;
		end else if (WR_I) begin
			// both are written separately; software retunes frequency with two writes
			if (ADDR_I == TCC_OFS_DIV)
				tick_divider_value <= WDATA_I[CNT_W-1:0];
			if (ADDR_I == TCC_OFS_WRAP)
				wrap_limit_value <= WDATA_I[CNT_W-1:0];
		end
	end

	assign tick = enable && div_count == tick_divider_value;

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I || !enable || tick)
			div_count <= '0;
		else
			div_count <= CNT_W'(div_count + 1'b1);
	end

	// ==========================================================
	// encoder inputs: always channels zero and one, whatever channel was named
	assign chan_first_input = CHAN_I[0];
	assign chan_second_input = CHAN_I[1];
	assign first_chg = chan_first_input != in_prev[0];
	assign second_chg = chan_second_input != in_prev[1];

	always_comb begin
		case (enc)
			TCC_QUAD_COUNT_FIRST_ONLY: enc_step = first_chg;
			TCC_QUAD_COUNT_SECOND_ONLY: enc_step = second_chg;
			TCC_QUAD_COUNT_BOTH: enc_step = first_chg || second_chg;
			default: enc_step = 1'b0;
		endcase
	end

	// a simultaneous change of both lines is invalid quadrature; first line decides
	assign enc_up = first_chg ? (chan_first_input != chan_second_input)
		: (chan_second_input == chan_first_input);
	assign step = (enc != TCC_ENC_OFF) ? (enable && enc_step) : tick;

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I)
			in_prev <= '0;
		else
			in_prev <= CHAN_I;
	end

	// ==========================================================
	// next count
	always_comb begin
		next_count = count;
		next_down_phase = down_phase;
		wrap_event = 1'b0;
		if (enc != TCC_ENC_OFF) begin
			if (enc_up) begin
				wrap_event = count == wrap_limit_value;
				next_count = wrap_event ? '0 : CNT_W'(count + 1'b1);
			end else begin
				wrap_event = count == '0;
				next_count = wrap_event ? wrap_limit_value : CNT_W'(count - 1'b1);
			end
		end else begin
			case (dir)
				TCC_DIR_DOWN: begin
					wrap_event = count == '0;
					next_count = wrap_event ? wrap_limit_value : CNT_W'(count - 1'b1);
				end
				TCC_DIR_CENTER: begin
					// a zero wrap limit parks the counter at zero
					if (wrap_limit_value == '0) begin
						next_count = '0;
						wrap_event = 1'b1;
					end else if (!down_phase) begin
						if (count >= wrap_limit_value) begin
							next_count = CNT_W'(count - 1'b1);
							next_down_phase = 1'b1;
						end else
							next_count = CNT_W'(count + 1'b1);
					end else if (count == '0) begin
						wrap_event = 1'b1;
						next_count = CNT_W'(count + 1'b1);
						next_down_phase = 1'b0;
					end else
						next_count = CNT_W'(count - 1'b1);
				end
				default: begin
					wrap_event = count >= wrap_limit_value;
					next_count = wrap_event ? '0 : CNT_W'(count + 1'b1);
				end
			endcase
		end
	end

	// ==========================================================
	// counter: software write wins over a step in the same cycle
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			count <= '0;
			down_phase <= 1'b0;
		end else if (wr_count) begin
			count <= WDATA_I[CNT_W-1:0];
			down_phase <= 1'b0;
		end else if (step) begin
			count <= next_count;
			down_phase <= next_down_phase;
		end
	end

	// ==========================================================
	// channels
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++) begin : g_chan
			always_ff @(posedge CLOCK_I) begin
				if (SRST_I) begin
					mode[gi] <= TCC_MATCH_TIMING_MODE;
					pol_low[gi] <= 1'b0;
					edge_sel[gi] <= TCC_EDGE_RISE;
				end else if (WR_I && chan_hit(ADDR_I, TCC_OFS_CFG_BASE, gi)) begin
					mode[gi] <= tcc_mode_t'(WDATA_I[TCC_CFG_MODE_LSB +: 4]);
					pol_low[gi] <= WDATA_I[TCC_CFG_POL_BIT];
					edge_sel[gi] <= tcc_edge_t'(WDATA_I[TCC_CFG_EDGE_LSB +: 2]);
				end
			end

			// one value serves as width, threshold or latched count
			always_ff @(posedge CLOCK_I) begin
				if (SRST_I)
					value[gi] <= '0;
				else if (WR_I && chan_hit(ADDR_I, TCC_OFS_VAL_BASE, gi))
					value[gi] <= WDATA_I[CNT_W:0];
				else if (cap_req[gi])
					value[gi] <= {1'b0, count};
			end

			tcc_chan #(
				.CNT_W(CNT_W)
			) u_chan (
				.clk_i(CLOCK_I),
				.srst_i(SRST_I),
				.mode_i(mode[gi]),
				.pol_low_i(pol_low[gi]),
				.edge_i(edge_sel[gi]),
				.center_i(dir == TCC_DIR_CENTER && enc == TCC_ENC_OFF),
				.count_i(count),
				.wrap_i(wrap_limit_value),
				.step_i(step),
				.value_i(value[gi]),
				.in_now_i(CHAN_I[gi]),
				.in_prev_i(in_prev[gi]),
				.pin_o(pin[gi]),
				.pin_n_o(pin_n[gi]),
				.oe_o(pin_oe[gi]),
				.capture_o(cap_req[gi]),
				.event_o(chan_event[gi])
			);
		end
	endgenerate

	assign CHAN_O = pin;
	assign CHAN_N_O = pin_n;
	assign CHAN_OE_O = pin_oe;

	// ==========================================================
	// events, mask and interrupt; a new event beats a clear in the same cycle
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I)
			status <= '0;
		else
			status <= (status & ~(wr_status ? WDATA_I[NCH:0] : '0))
				| {step && wrap_event, chan_event};
	end

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I)
			mask <= '0;
		else if (WR_I && ADDR_I == TCC_OFS_MASK)
			mask <= WDATA_I[NCH:0];
	end

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I)
			IRQ_O <= 1'b0;
		else
			IRQ_O <= |(status & mask);
	end

	// ==========================================================
	// read path: data one cycle after the strobe, zero otherwise
	always_comb begin
		read_word = '0;
		case (ADDR_I)
			TCC_OFS_CTRL: begin
				read_word[TCC_CTRL_EN_BIT] = enable;
				read_word[TCC_CTRL_DIR_LSB +: 2] = dir;
				read_word[TCC_CTRL_ENC_LSB +: 2] = enc;
			end
			TCC_OFS_COUNT: read_word[CNT_W-1:0] = count;
			TCC_OFS_DIV: read_word[CNT_W-1:0] = tick_divider_value;
			TCC_OFS_WRAP: read_word[CNT_W-1:0] = wrap_limit_value;
			TCC_OFS_STATUS: read_word[NCH:0] = status;
			TCC_OFS_MASK: read_word[NCH:0] = mask;
			default: begin
				for (int i = 0; i < NCH; i++) begin
					if (chan_hit(ADDR_I, TCC_OFS_CFG_BASE, i)) begin
						read_word[TCC_CFG_MODE_LSB +: 4] = mode[i];
						read_word[TCC_CFG_POL_BIT] = pol_low[i];
						read_word[TCC_CFG_EDGE_LSB +: 2] = edge_sel[i];
					end
					if (chan_hit(ADDR_I, TCC_OFS_VAL_BASE, i))
						read_word[CNT_W:0] = value[i];
				end
			end
		endcase
	end

	always_ff @(posedge CLOCK_I) begin
		if (SRST_I || !RD_I)
			RDATA_O <= '0;
		else
			RDATA_O <= read_word;
	end
endmodule : tcc_timer

// ==== bench/tcc_monitor.sv ====
// Purpose: port-level checks of the timer block
// Assumes: one clock, synchronous active-high reset
// Notes: shadows mask and channel zero config from bus writes
`timescale 1ns/1ps
module tcc_monitor
	import tcc_pkg::*;
#(
	parameter int CNT_W = TCC_CNT_W,
	parameter int NCH = TCC_NCH
) (
	// clock and reset
	input wire logic CLOCK_I,
	input wire logic SRST_I,
	// register port
	input wire logic [TCC_ADDR_W-1:0] ADDR_I,
	input wire logic [TCC_DATA_W-1:0] WDATA_I,
	input wire logic WR_I,
	input wire logic RD_I,
	input wire logic [TCC_DATA_W-1:0] RDATA_O,
	// pins and interrupt
	input wire logic [NCH-1:0] CHAN_I,
	input wire logic [NCH-1:0] CHAN_O,
	input wire logic [NCH-1:0] CHAN_N_O,
	input wire logic [NCH-1:0] CHAN_OE_O,
	input wire logic IRQ_O
);
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (SRST_I);
	// ========
	// shadows
	logic [TCC_DATA_W-1:0] mask;
	logic [4:0] cfg0;
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			mask <= 32'h0;
		end else if (WR_I && ADDR_I == TCC_OFS_MASK) begin
			mask <= WDATA_I;
		end
	end
	always_ff @(posedge CLOCK_I) begin
		if (SRST_I) begin
			cfg0 <= 5'h02;
		end else if (WR_I && ADDR_I == TCC_OFS_CFG_BASE) begin
			cfg0 <= WDATA_I[4:0];
		end
	end
	// ========
	// sequences
	sequence wr_at(logic [7:0] a);
		WR_I && ADDR_I == a;
	endsequence
	sequence rd_at(logic [7:0] a);
		RD_I && ADDR_I == a;
	endsequence
	// ========
	// properties
	a_read_idle: assert property (!RD_I |=> RDATA_O == 32'h0)
		else $error("read data not zero outside a read");
	a_unmapped_zero: assert property (rd_at(8'hFC) |=> RDATA_O == 32'h0)
		else $error("unmapped read not zero");
	a_wrap_readback: assert property (wr_at(TCC_OFS_WRAP) ##1 rd_at(TCC_OFS_WRAP)
		|=> RDATA_O == 32'($past(WDATA_I[CNT_W-1:0], 2))) else $error("wrap readback wrong");
	a_div_readback: assert property (wr_at(TCC_OFS_DIV) ##1 rd_at(TCC_OFS_DIV)
		|=> RDATA_O == 32'($past(WDATA_I[CNT_W-1:0], 2))) else $error("divider readback wrong");
	a_pins_paired: assert property (!$past(SRST_I) |-> CHAN_N_O == ~CHAN_O)
		else $error("complement pin not inverse");
	a_reset_quiet: assert property ($fell(SRST_I) |-> !CHAN_OE_O && !IRQ_O)
		else $error("outputs active after reset");
	a_irq_masked: assert property ((mask[NCH:0] == 0) [*2] |-> !IRQ_O)
		else $error("interrupt while all masked");
	// two cycles of margin for the registered pin path
	a_forced_level: assert property ((cfg0[3:1] == 3'h3 && $stable(cfg0)) [*3]
		|-> CHAN_O[0] == ((cfg0[3:0] == 4'h6) ^ cfg0[4]) && CHAN_OE_O[0])
		else $error("forced pin level wrong");
	a_timing_undriven: assert property (((cfg0[3:0] == 4'h2 || cfg0[3:0] == 4'h8)
		&& $stable(cfg0)) [*3] |-> !CHAN_OE_O[0]) else $error("pin driven in timing mode");
endmodule : tcc_monitor

// ==== bench/tcc_pins.sv ====
// Purpose: pin-side model driving the channel inputs
// Assumes: bench requests change just after a rising edge
// Notes: quadrature phase only ever reaches the first two lines
`timescale 1ns/1ps
module tcc_pins
	import tcc_pkg::*;
#(
	parameter int NCH = TCC_NCH
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic srst_i,
	// requests
	input wire logic [NCH-1:0] lvl_i,
	input wire logic quad_i,
	input wire logic fwd_i,
	input wire logic back_i,
	// pins
	output logic [NCH-1:0] pins_o
);
	logic [1:0] phase;
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			phase <= 2'h0;
		end else if (fwd_i) begin
			phase <= phase + 2'h1;
		end else if (back_i) begin
			phase <= phase - 2'h1;
		end
	end
	always_comb begin
		pins_o = lvl_i;
		if (quad_i) begin
			pins_o[0] = phase == 2'h1 || phase == 2'h2;
			pins_o[1] = phase[1];
		end
	end
endmodule : tcc_pins

// ==== bench/tcc_timer_bench.sv ====
// Purpose: self-checking bench of the timer block
// Assumes: default parameters, four channels
// Notes: latch test runs with the counter stopped so captures are known
`timescale 1ns/1ps
module tcc_timer_bench
	import tcc_pkg::*;
;
	localparam logic [7:0] ctl = TCC_OFS_CTRL, cnt = TCC_OFS_COUNT, dvr = TCC_OFS_DIV;
	localparam logic [7:0] wrp = TCC_OFS_WRAP, sts = TCC_OFS_STATUS, msk = TCC_OFS_MASK;
	localparam logic [7:0] cf0 = TCC_OFS_CFG_BASE, vl0 = TCC_OFS_VAL_BASE;
	localparam logic [7:0] cf1 = cf0 + TCC_CHAN_STRIDE, vl1 = vl0 + TCC_CHAN_STRIDE;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic quad = 1'b0;
	logic fwd = 1'b0;
	logic back = 1'b0;
	logic [3:0] lvl = 4'h0;
	logic [3:0] pins, pout, pn, poe;
	logic [31:0] rdata, rdv;
	logic irq;
	int mismatches = 0;
	int n_compared = 0;
	int cycles = 0;
	tcc_pins u_pins (.clk_i(clk), .srst_i(srst), .lvl_i(lvl), .quad_i(quad), .fwd_i(fwd),
		.back_i(back), .pins_o(pins));
	tcc_timer dut (.CLOCK_I(clk), .SRST_I(srst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
		.RD_I(rd), .RDATA_O(rdata), .CHAN_I(pins), .CHAN_O(pout), .CHAN_N_O(pn),
		.CHAN_OE_O(poe), .IRQ_O(irq));
	// ========
	// helpers
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk
	// strobes reassigned every cycle so no signal changes twice in a step
	task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
		wr <= w;
		rd <= r;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		#1;
		rdv = rdata;
	endtask : bus
	task automatic wrt(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, 1'b0, a, d);
	endtask : wrt
	task automatic idle(input int n = 1);
		repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0);
	endtask : idle
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, 1'b1, a, 32'h0);
		chk(rdv, e);
	endtask : rdc
	task automatic high(input int ch, input int n, output int h);
		idle(8);
		h = 0;
		repeat (n) begin
			idle();
			h += (pout[ch] === 1'b1);
		end
	endtask : high
	task automatic wait_irq(output int n);
		n = 0;
		while (irq !== 1'b1 && n < 200) begin
			idle();
			n++;
		end
	endtask : wait_irq
	task automatic qstep(input logic f, input int n);
		repeat (n) begin
			fwd <= f;
			back <= !f;
			idle();
			fwd <= 1'b0;
			back <= 1'b0;
			idle(2);
		end
	endtask : qstep
	// ========
	// scenarios
	task automatic t_regs();
		rdc(ctl, 32'h0);
		rdc(wrp, 32'hFFFF);
		rdc(msk, 32'h0);
		rdc(cf0, 32'h2);
		rdc(vl0, 32'h0);
		wrt(8'hFC, 32'h5);
		rdc(8'hFC, 32'h0);
		wrt(wrp, 32'h63);
		rdc(wrp, 32'h63);
		wrt(dvr, 32'h7);
		rdc(dvr, 32'h7);
		wrt(cnt, 32'h5);
		rdc(cnt, 32'h5);
		$display("test regs done");
	endtask : t_regs
	task automatic t_period();
		int n;
		for (int d = 0; d < 4; d++) begin
			wrt(ctl, 32'h0);
			wrt(dvr, 32'h1);
			wrt(wrp, 32'h2);
			wrt(cnt, 32'h0);
			wrt(msk, 32'h10);
			wrt(sts, 32'h1F);
			wrt(ctl, 32'(1 + 2 * d));
			wait_irq(n);
			wrt(sts, 32'h10);
			idle();
			wait_irq(n);
			chk(n + 2, (d == 2) ? 8 : 6);
		end
		wrt(msk, 32'h0);
		$display("test period done");
	endtask : t_period
	task automatic t_pwm();
		int h;
		wrt(ctl, 32'h0);
		wrt(dvr, 32'h0);
		wrt(wrp, 32'h3);
		wrt(cf1, 32'h0);
		wrt(ctl, 32'h1);
		for (int v = 0; v < 5; v++) begin
			wrt(vl1, 32'(v));
			rdc(vl1, 32'(v));
			high(1, 8, h);
			chk(h, 2 * v);
		end
		// software turns a duty percent into a width: half of a four-tick period
		wrt(vl1, 32'(50 * (3 + 1) / 100));
		high(1, 8, h);
		chk(h, 4);
		chk(poe[1], 1'b1);
		wrt(cf1, 32'h1);
		wrt(vl1, 32'h1);
		high(1, 8, h);
		chk(h, 6);
		wrt(cf1, 32'h0);
		wrt(ctl, 32'h5);
		for (int v = 2; v < 4; v++) begin
			wrt(vl1, 32'(v));
			high(1, 12, h);
			chk(h, 6 * v - 6);
		end
		$display("test pwm done");
	endtask : t_pwm
	task automatic t_cmp();
		int h;
		logic [3:0] m;
		wrt(ctl, 32'h1);
		wrt(vl0, 32'h1);
		for (int i = 0; i < 8; i++) begin
			m = 4'(3 + i / 2 + i / 4);
			wrt(cf0, 32'(m + 16 * (i % 2)));
			idle(8);
			chk(pout[0], (m == 4'h3 || m == 4'h6) ^ (i % 2 == 1));
		end
		wrt(cf0, 32'h5);
		high(0, 8, h);
		chk(h, 4);
		wrt(cf0, 32'h2);
		wrt(sts, 32'h1F);
		wrt(msk, 32'h1);
		idle(8);
		chk(irq, 1'b1);
		chk(poe[0], 1'b0);
		wrt(msk, 32'h0);
		idle(2);
		chk(irq, 1'b0);
		wrt(ctl, 32'h0);
		idle(2);
		wrt(sts, 32'h1F);
		rdc(sts, 32'h0);
		$display("test compare done");
	endtask : t_cmp
	task automatic t_latch();
		for (int e = 0; e < 3; e++) begin
			wrt(cf0, 32'(8 + 32 * e));
			wrt(cnt, 32'(11 + e));
			wrt(vl0, 32'h0);
			lvl <= 4'h1;
			idle(3);
			rdc(vl0, (e == 1) ? 32'h0 : 32'(11 + e));
			wrt(cnt, 32'(21 + e));
			lvl <= 4'h0;
			idle(3);
			rdc(vl0, (e == 0) ? 32'(11 + e) : 32'(21 + e));
		end
		wrt(cf0, 32'h2);
		$display("test latch done");
	endtask : t_latch
	task automatic t_enc();
		quad <= 1'b1;
		wrt(wrp, 32'hFFFF);
		wrt(cnt, 32'hA);
		wrt(ctl, 32'h19);
		qstep(1'b1, 4);
		rdc(cnt, 32'hE);
		qstep(1'b0, 2);
		rdc(cnt, 32'hC);
		lvl <= 4'hC;
		idle(3);
		rdc(cnt, 32'hC);
		wrt(ctl, 32'h9);
		qstep(1'b1, 4);
		rdc(cnt, 32'hE);
		wrt(ctl, 32'h11);
		qstep(1'b1, 4);
		rdc(cnt, 32'h10);
		wrt(wrp, 32'h3);
		wrt(cnt, 32'h0);
		wrt(ctl, 32'h19);
		qstep(1'b0, 1);
		rdc(cnt, 32'h3);
		$display("test encoder done");
	endtask : t_enc
	// mid-run reset: registers and pins must come back to their reset values
	task automatic t_reset();
		wrt(msk, 32'h1F);
		srst <= 1'b1;
		idle(3);
		srst <= 1'b0;
		rdc(msk, 32'h0);
		rdc(cnt, 32'h0);
		rdc(ctl, 32'h0);
		chk(poe, 32'h0);
		chk(pout, 32'h0);
		$display("test reset done");
	endtask : t_reset
	// ========
	// run control
	initial begin
		forever #2.5 clk = ~clk;
	end
	// whole run needs well under two thousand cycles
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			mismatches++;
			complete_run();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		#1;
		t_regs();
		t_period();
		t_pwm();
		t_cmp();
		t_latch();
		t_enc();
		t_reset();
		complete_run();
	end
endmodule : tcc_timer_bench
bind tcc_timer tcc_monitor #(.CNT_W(CNT_W), .NCH(NCH)) u_mon (.CLOCK_I(CLOCK_I),
	.SRST_I(SRST_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
	.RDATA_O(RDATA_O), .CHAN_I(CHAN_I), .CHAN_O(CHAN_O), .CHAN_N_O(CHAN_N_O),
	.CHAN_OE_O(CHAN_OE_O), .IRQ_O(IRQ_O));
